// [mtq_map.vh]
// Purpose: Constants for the trigger sequencer and error queue block
// Assumes: 20 MHz clock; register port with one-cycle read latency
// Notes:   Offsets are word indexes on the plain register port
`ifndef MTQ_MAP_VH
`define MTQ_MAP_VH
`define MTQ_CLK_HZ        20000000
// Register offsets
`define MTQ_A_CMD         4'h0
`define MTQ_A_COUNT       4'h1
`define MTQ_A_DELAY       4'h2
`define MTQ_A_CONF        4'h3
`define MTQ_A_ERRQ        4'h4
`define MTQ_A_QEVENT      4'h5
`define MTQ_A_QENABLE     4'h6
`define MTQ_A_STATUS      4'h7
`define MTQ_A_VERSION     4'h8
`define MTQ_A_ERRPUSH     4'h9
`define MTQ_A_LIMITS      4'hA
// Command bits in MTQ_A_CMD
`define MTQ_C_INIT        0
`define MTQ_C_READ        1
`define MTQ_C_BUSTRIG     2
`define MTQ_C_CLS         3
`define MTQ_C_RST         4
`define MTQ_C_CONFIGURE   5
`define MTQ_C_COUNT_MIN   6
`define MTQ_C_COUNT_MAX   7
`define MTQ_C_COUNT_INF   8
`define MTQ_C_DEL_MIN     9
`define MTQ_C_DEL_MAX     10
// CONF fields
`define MTQ_F_AUTO        0
`define MTQ_F_SRC_LO      1
`define MTQ_F_FUNC_LO     3
`define MTQ_F_RANGE_LO    6
`define MTQ_F_PLC1        9
`define MTQ_F_FILT_LO     10
// Trigger sources
`define MTQ_SRC_IMM       2'h0
`define MTQ_SRC_BUS       2'h1
`define MTQ_SRC_EXT       2'h2
`define MTQ_SRC_BPL       2'h3
// Functions
`define MTQ_FN_DC         3'h0
`define MTQ_FN_OHM        3'h1
`define MTQ_FN_AC         3'h2
`define MTQ_FN_FREQ       3'h3
// Resistance ranges, 100 ohm up to 100 Mohm
`define MTQ_R_1M          3'h4
`define MTQ_R_10M         3'h5
// AC filter
`define MTQ_FL_SLOW       2'h0
`define MTQ_FL_MED        2'h1
// Limits
`define MTQ_COUNT_MIN     16'h0001
`define MTQ_COUNT_MAX     16'hC350
`define MTQ_DELAY_MAX_S   12'hE10
`define MTQ_STORE_DEPTH   16'h0010
`define MTQ_ERRQ_DEPTH    20
// Error codes, 16 bit two's complement
`define MTQ_E_NONE        16'h0000
`define MTQ_E_OVERFLOW    16'hFEA2
`define MTQ_E_TRIG_IGN    16'hFF25
`define MTQ_E_NO_MEM      16'hFEAA
// Message ids
`define MTQ_M_NONE        8'h00
`define MTQ_M_OVERFLOW    8'h01
`define MTQ_M_TRIG_IGN    8'h02
`define MTQ_M_NO_MEM      8'h03
// Auto delays in microseconds
`define MTQ_D_1MS0_US     32'd1000
`define MTQ_D_1MS5_US     32'd1500
`define MTQ_D_10MS_US     32'd10000
`define MTQ_D_100MS_US    32'd100000
`define MTQ_D_600MS_US    32'd600000
`define MTQ_D_1S0_US      32'd1000000
`define MTQ_D_7S0_US      32'd7000000
`define MTQ_TICKS_PER_US  (`MTQ_CLK_HZ / 1000000)
// Version YYYY.R as BCD year and digit
`define MTQ_VERSION       20'h19910
// Questionable event width
`define MTQ_QW            16
`endif

// [mtq_core.v]
// Purpose: Trigger sequencer, error queue and questionable event query
// Assumes: Synchronous inputs, 20 MHz clock, read data one cycle late
// Notes:   Delay seconds become ticks by a microsecond prescaler
`timescale 1ns/1ns
`default_nettype none
`include "mtq_map.vh"
module mtq_core #(
  parameter DEPTH    = `MTQ_ERRQ_DEPTH,
  parameter STORE    = `MTQ_STORE_DEPTH,
  parameter US_TICKS = `MTQ_TICKS_PER_US
) (
  input  wire        i_mclk,
  input  wire        i_rstn,
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire        i_ext_trig_n,
  input  wire [7:0]  i_backplane_trigger_lines,
  input  wire [2:0]  i_bpl_sel,
  input  wire        i_meas_done,
  input  wire [`MTQ_QW-1:0] i_quest_set,
  output reg  [31:0] o_rdata,
  output reg         o_meas_start,
  output reg         o_waiting,
  output reg         o_busy,
  output reg         o_questionable_summary_bit
);
  localparam S_IDLE = 4'b0001;
  localparam S_WAIT = 4'b0010;
  localparam S_DLY  = 4'b0100;
  localparam S_MEAS = 4'b1000;

  reg  [15:0] trig_count;
  reg         count_inf;
  reg  [11:0] delay_s;
  reg  [15:0] samples_per_trigger;
  reg  [15:0] conf;
  reg  [`MTQ_QW-1:0] qevent;
  reg  [`MTQ_QW-1:0] qenable;
  reg  [3:0]  state;
  reg  [15:0] trig_done;
  reg  [15:0] samp_done;
  reg  [31:0] dly_us;
  reg  [7:0]  us_pre;
  reg         ext_prev;
  reg  [23:0] err_mem [0:DEPTH-1];
  reg  [4:0]  rd_ptr;
  reg  [4:0]  wr_ptr;
  reg  [4:0]  level;
  reg         ovf;
  wire        automatic_delay_flag = conf[`MTQ_F_AUTO];
  wire [1:0]  src  = conf[`MTQ_F_SRC_LO+1:`MTQ_F_SRC_LO];
  wire [2:0]  fn   = conf[`MTQ_F_FUNC_LO+2:`MTQ_F_FUNC_LO];
  wire [2:0]  rng  = conf[`MTQ_F_RANGE_LO+2:`MTQ_F_RANGE_LO];
  wire        integration_line_cycles = conf[`MTQ_F_PLC1];
  wire [1:0]  filt = conf[`MTQ_F_FILT_LO+1:`MTQ_F_FILT_LO];

  wire wr_cmd = i_wr && (i_addr == `MTQ_A_CMD);
  wire c_init = wr_cmd && (i_wdata[`MTQ_C_INIT] || i_wdata[`MTQ_C_READ]);
  wire c_store = wr_cmd && i_wdata[`MTQ_C_INIT] && !i_wdata[`MTQ_C_READ];
  wire c_bus  = wr_cmd && i_wdata[`MTQ_C_BUSTRIG];
  wire c_cls  = wr_cmd && i_wdata[`MTQ_C_CLS];
  wire c_rst  = wr_cmd && i_wdata[`MTQ_C_RST];
  wire c_conf = wr_cmd && i_wdata[`MTQ_C_CONFIGURE];
  wire rd_err = i_rd && (i_addr == `MTQ_A_ERRQ);
  wire rd_q   = i_rd && (i_addr == `MTQ_A_QEVENT);

  // Auto delay selection in microseconds
  reg [31:0] auto_us;
  always @* begin
    auto_us = `MTQ_D_1S0_US;
    case (fn)
      `MTQ_FN_DC: auto_us = integration_line_cycles ? `MTQ_D_1MS5_US
                                                   : `MTQ_D_1MS0_US;
      `MTQ_FN_OHM: begin
        if (rng >= `MTQ_R_10M)
          auto_us = `MTQ_D_100MS_US;
        else if (rng == `MTQ_R_1M)
          auto_us = integration_line_cycles ? `MTQ_D_1MS5_US : `MTQ_D_10MS_US;
        else
          auto_us = integration_line_cycles ? `MTQ_D_1MS5_US : `MTQ_D_1MS0_US;
      end
      `MTQ_FN_AC: begin
        if (filt == `MTQ_FL_SLOW)
          auto_us = `MTQ_D_7S0_US;
        else if (filt == `MTQ_FL_MED)
          auto_us = `MTQ_D_1S0_US;
        else
          auto_us = `MTQ_D_600MS_US;
      end
      default: auto_us = `MTQ_D_1S0_US;
    endcase
  end
  // auto flag chooses the table value
  wire [31:0] sel_us = automatic_delay_flag ? auto_us
                     : ({20'h00000, delay_s} * 32'd1000000);

  // Trigger source; external input fires on its falling edge
  wire ext_fall = ext_prev && !i_ext_trig_n;
  reg  trig_in;
  always @* begin
    case (src)
      `MTQ_SRC_IMM: trig_in = 1'b1;
      `MTQ_SRC_BUS: trig_in = c_bus;
      `MTQ_SRC_EXT: trig_in = ext_fall;
      default:      trig_in = i_backplane_trigger_lines[i_bpl_sel];
    endcase
  end
  wire trig_ign = c_bus && (state != S_WAIT);
  // Readings are count times samples; full product width avoids a wrap
  wire [31:0] readings = trig_count * samples_per_trigger;
  wire no_mem   = c_store && (count_inf || readings > {16'h0000, STORE[15:0]});

  // Error push: internal events first, else software push port
  wire        push_sw = i_wr && (i_addr == `MTQ_A_ERRPUSH);
  wire        push    = trig_ign || no_mem || push_sw;
  wire [23:0] push_e  = trig_ign ? {`MTQ_E_TRIG_IGN, `MTQ_M_TRIG_IGN}
                      : no_mem   ? {`MTQ_E_NO_MEM, `MTQ_M_NO_MEM}
                      : i_wdata[23:0];
  wire        empty   = (level == 5'd0);
  wire        pop     = rd_err && !empty;
  wire [4:0]  last    = (wr_ptr == 5'd0) ? DEPTH[4:0] - 5'd1 : wr_ptr - 5'd1;
  wire [4:0]  rd_nx   = (rd_ptr == DEPTH[4:0] - 5'd1) ? 5'd0 : rd_ptr + 5'd1;
  wire [4:0]  wr_nx   = (wr_ptr == DEPTH[4:0] - 5'd1) ? 5'd0 : wr_ptr + 5'd1;
  // A push with a full queue overwrites the newest entry with the marker, once until the next pop
  wire        full    = (level == DEPTH[4:0]);
  wire        do_push = push && (!full || pop);

  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_ptr <= 5'd0;
      wr_ptr <= 5'd0;
      level  <= 5'd0;
      ovf    <= 1'b0;
    end else if (c_cls) begin
      rd_ptr <= 5'd0;
      wr_ptr <= 5'd0;
      level  <= 5'd0;
      ovf    <= 1'b0;
    end else begin
      if (pop) begin
        rd_ptr <= rd_nx;
        ovf    <= 1'b0;
      end
      if (do_push) begin
        err_mem[wr_ptr] <= push_e;
        wr_ptr <= wr_nx;
      end else if (push && !ovf) begin
        err_mem[last] <= {`MTQ_E_OVERFLOW, `MTQ_M_OVERFLOW};
        ovf <= 1'b1;
      end
      if (do_push && !pop)
        level <= level + 5'd1;
      else if (pop && !do_push)
        level <= level - 5'd1;
    end
  end

  // Settings, event register and sequencer
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      trig_count <= `MTQ_COUNT_MIN;
      count_inf  <= 1'b0;
      delay_s    <= 12'h000;
      samples_per_trigger <= 16'h0001;
      conf       <= 16'h0001;
      qevent     <= {`MTQ_QW{1'b0}};
      qenable    <= {`MTQ_QW{1'b0}};
      state      <= S_IDLE;
      trig_done  <= 16'h0000;
      samp_done  <= 16'h0000;
      dly_us     <= 32'h00000000;
      us_pre     <= 8'h00;
      ext_prev   <= 1'b1;
      o_meas_start <= 1'b0;
      o_waiting  <= 1'b0;
      o_busy     <= 1'b0;
      o_questionable_summary_bit <= 1'b0;
    end else begin
      ext_prev <= i_ext_trig_n;
      o_meas_start <= 1'b0;
      // set wins over the read clear
      qevent <= (rd_q ? {`MTQ_QW{1'b0}} : qevent) | i_quest_set;
      o_questionable_summary_bit <= |(qevent & qenable);
      if (i_wr && i_addr == `MTQ_A_COUNT && i_wdata[31:16] == 16'h0000) begin
        if (i_wdata[15:0] >= `MTQ_COUNT_MIN && i_wdata[15:0] <= `MTQ_COUNT_MAX) begin
          trig_count <= i_wdata[15:0];
          count_inf  <= 1'b0;
        end
      end
      if (i_wr && i_addr == `MTQ_A_DELAY && i_wdata[31:12] == 20'h00000 &&
          i_wdata[11:0] <= `MTQ_DELAY_MAX_S) begin
        delay_s <= i_wdata[11:0];
        conf[`MTQ_F_AUTO] <= 1'b0;
      end
      if (i_wr && i_addr == `MTQ_A_CONF) begin
        conf <= {4'h0, i_wdata[11:0]};
        if (i_wdata[31:16] != 16'h0000)
          samples_per_trigger <= i_wdata[31:16];
      end
      if (i_wr && i_addr == `MTQ_A_QENABLE)
        qenable <= i_wdata[`MTQ_QW-1:0];
      if (wr_cmd) begin
        if (i_wdata[`MTQ_C_COUNT_MIN]) begin
          trig_count <= `MTQ_COUNT_MIN;
          count_inf  <= 1'b0;
        end
        if (i_wdata[`MTQ_C_COUNT_MAX]) begin
          trig_count <= `MTQ_COUNT_MAX;
          count_inf  <= 1'b0;
        end
        if (i_wdata[`MTQ_C_COUNT_INF])
          count_inf <= 1'b1;
        if (i_wdata[`MTQ_C_DEL_MIN]) begin
          delay_s <= 12'h000;
          conf[`MTQ_F_AUTO] <= 1'b0;
        end
        if (i_wdata[`MTQ_C_DEL_MAX]) begin
          delay_s <= `MTQ_DELAY_MAX_S;
          conf[`MTQ_F_AUTO] <= 1'b0;
        end
        if (c_conf) begin
          trig_count <= `MTQ_COUNT_MIN;
          count_inf  <= 1'b0;
          conf[`MTQ_F_SRC_LO+1:`MTQ_F_SRC_LO] <= `MTQ_SRC_IMM;
        end
        if (c_rst) begin
          trig_count <= `MTQ_COUNT_MIN;
          count_inf  <= 1'b0;
          conf       <= 16'h0001;
          samples_per_trigger <= 16'h0001;
          state      <= S_IDLE;
        end
      end
      if (!c_rst) begin
        case (state)
          S_IDLE: begin
            if (c_init && !no_mem) begin
              state <= S_WAIT;
              trig_done <= 16'h0000;
            end
          end
          S_WAIT: begin
            if (trig_in) begin
              dly_us    <= sel_us;
              us_pre    <= 8'h00;
              samp_done <= 16'h0000;
              state     <= S_DLY;
            end
          end
          S_DLY: begin
            // Prescaler gives a one-cycle microsecond enable
            if (dly_us == 32'h00000000) begin
              o_meas_start <= 1'b1;
              state <= S_MEAS;
            end else if (us_pre == US_TICKS[7:0] - 8'h01) begin
              us_pre <= 8'h00;
              dly_us <= dly_us - 32'h00000001;
            end else begin
              us_pre <= us_pre + 8'h01;
            end
          end
          S_MEAS: begin
            if (i_meas_done) begin
              if (samp_done + 16'h0001 < samples_per_trigger) begin
                samp_done <= samp_done + 16'h0001;
                dly_us <= sel_us;
                us_pre <= 8'h00;
                state  <= S_DLY;
              end else if (!count_inf && trig_done + 16'h0001 >= trig_count) begin
                state <= S_IDLE;
              end else begin
                trig_done <= trig_done + 16'h0001;
                state <= S_WAIT;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
      o_waiting <= (state == S_WAIT);
      o_busy    <= (state != S_IDLE);
    end
  end

  // Read port, data one cycle after the strobe
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `MTQ_A_COUNT:   o_rdata <= {15'h0000, count_inf, trig_count};
        `MTQ_A_DELAY:   o_rdata <= {20'h00000, delay_s};
        `MTQ_A_CONF:    o_rdata <= {samples_per_trigger, conf};
        `MTQ_A_ERRQ:    o_rdata <= empty ? {8'h00, `MTQ_E_NONE, `MTQ_M_NONE}
                                         : {8'h00, err_mem[rd_ptr]};
        `MTQ_A_QEVENT:  o_rdata <= {{(32-`MTQ_QW){1'b0}}, qevent};
        `MTQ_A_QENABLE: o_rdata <= {{(32-`MTQ_QW){1'b0}}, qenable};
        `MTQ_A_STATUS:  o_rdata <= {20'h00000, ovf, level, state, o_questionable_summary_bit,
                                    o_busy};
        `MTQ_A_VERSION: o_rdata <= {12'h000, `MTQ_VERSION};
        `MTQ_A_LIMITS:  o_rdata <= {`MTQ_COUNT_MAX, 4'h0, `MTQ_DELAY_MAX_S};
        default:        o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end
endmodule // mtq_core
`default_nettype wire

// [mtq_core_asserts.sv]
// Purpose: Port checks for mtq_core
// Assumes: One clock, async active-low reset
// Notes:   Sees only the top ports
`timescale 1ns/1ns
`default_nettype none
module mtq_core_chk #(
  parameter DEPTH = 20
) (
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [15:0] i_quest_set,
  input wire logic [31:0] o_rdata,
  input wire logic        o_meas_start,
  input wire logic        o_waiting,
  input wire logic        o_busy
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_version; $past(i_rd) && $past(i_addr) == 4'h8 |-> o_rdata == 32'h00019910; endproperty
  a_version: assert property (p_version) else $error("bad version");
  property p_limits; $past(i_rd) && $past(i_addr) == 4'hA |-> o_rdata == 32'hC3500E10; endproperty
  a_limits: assert property (p_limits) else $error("bad limits");
  property p_qclr;
    $past(i_rd, 2) && $past(i_addr, 2) == 4'h5 && $past(i_rd) && $past(i_addr) == 4'h5 &&
      $past(i_quest_set, 2) == 16'h0 && $past(i_quest_set) == 16'h0 |-> o_rdata == 32'h0;
  endproperty
  a_qclr: assert property (p_qclr) else $error("event not cleared by read");
  property p_empty;
    $past(i_rd, 2) && $past(i_addr, 2) == 4'h4 && $past(i_rd) && $past(i_addr) == 4'h4 &&
      $past(o_rdata) == 32'h0 |-> o_rdata == 32'h0;
  endproperty
  a_empty: assert property (p_empty) else $error("empty queue changed");
  property p_level; $past(i_rd) && $past(i_addr) == 4'h7 |-> o_rdata[10:6] <= DEPTH; endproperty
  a_level: assert property (p_level) else $error("queue level too high");
  property p_pulse; o_meas_start |=> !o_meas_start; endproperty
  a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
  property p_start_busy; o_meas_start |-> o_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start while idle");
  property p_wait_busy; o_waiting |-> o_busy; endproperty
  a_wait_busy: assert property (p_wait_busy) else $error("waiting while idle");
endmodule // mtq_core_chk
bind mtq_core mtq_core_chk #(.DEPTH(DEPTH)) u_chk (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd),
  .i_quest_set(i_quest_set), .o_rdata(o_rdata), .o_meas_start(o_meas_start),
  .o_waiting(o_waiting), .o_busy(o_busy));
`default_nettype wire

// [mtq_front.sv]
// Purpose: Measurement front end answering start pulses
// Assumes: Done three cycles after each start
// Notes:   Counts starts so the bench sees triggers serviced
`timescale 1ns/1ns
`default_nettype none
module mtq_front (
  input  wire logic       i_mclk,
  input  wire logic       i_rstn,
  input  wire logic       i_start,
  output var  logic       o_done,
  output var  logic [7:0] o_starts
);
  logic [1:0] sr;
  always @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sr <= 2'h0;
      o_done <= 1'b0;
      o_starts <= 8'h00;
    end else begin
      sr <= {sr[0], i_start};
      o_done <= sr[1];
      o_starts <= o_starts + {7'h00, i_start};
    end
  end
endmodule // mtq_front
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for mtq_core
// Assumes: Microsecond prescaler shortened to one tick
// Notes:   Backplane trigger lines tied off
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_ext_trig_n = 1'b1;
  logic [15:0] i_quest_set = 16'h0;
  wire  [31:0] o_rdata;
  wire         o_meas_start, o_waiting, o_busy, o_questionable_summary_bit, done;
  wire  [7:0]  starts;
  logic [7:0]  s0;
  int          fails = 0, comparisons = 0, i, n, m;
  logic [71:0] rows [18] = '{
    {4'h1,32'h0000000A,4'h1,32'h0000000A}, {4'h1,32'h00000000,4'h1,32'h0000000A},
    {4'h1,32'h0000C351,4'h1,32'h0000000A}, {4'h0,32'h00000080,4'h1,32'h0000C350},
    {4'h0,32'h00000040,4'h1,32'h00000001}, {4'h0,32'h00000400,4'h2,32'h00000E10},
    {4'h2,32'h00000E11,4'h2,32'h00000E10}, {4'h0,32'h00000200,4'h2,32'h00000000},
    {4'h2,32'h00000000,4'h3,32'h00010000}, {4'h1,32'h00000007,4'h1,32'h00000007},
    {4'h0,32'h00000010,4'h1,32'h00000001}, {4'h0,32'h00000000,4'h3,32'h00010001},
    {4'h2,32'h00000005,4'h3,32'h00010000}, {4'h2,32'h00001000,4'h2,32'h00000005},
    {4'h1,32'h00000005,4'h1,32'h00000005}, {4'h1,32'h00010003,4'h1,32'h00000005},
    {4'h0,32'h00000100,4'h1,32'h00010005}, {4'h0,32'h00000020,4'h1,32'h00000001}};
  logic [31:0] cf [4] = '{32'h00010001, 32'h00010201, 32'h00010109, 32'h00020001};
  int          tk [4] = '{1000, 1500, 10000, 1000};
  int          ns [4] = '{1, 1, 1, 2};
  always #25 i_mclk = ~i_mclk;
  mtq_core #(.US_TICKS(1)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_ext_trig_n(i_ext_trig_n), .i_backplane_trigger_lines(8'h00),
    .i_bpl_sel(3'h0), .i_meas_done(done), .i_quest_set(i_quest_set), .o_rdata(o_rdata),
    .o_meas_start(o_meas_start), .o_waiting(o_waiting), .o_busy(o_busy),
    .o_questionable_summary_bit(o_questionable_summary_bit));
  mtq_front front (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(o_meas_start), .o_done(done),
    .o_starts(starts));
  task stop_test;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk) begin i_addr <= a; i_wdata <= d; i_wr <= 1'b1; end
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk) begin i_addr <= a; i_rd <= 1'b1; end
    @(posedge i_mclk) i_rd <= 1'b0;
    @(negedge i_mclk) chk(o_rdata, e);
  endtask
  // Two reads with no gap: second sees the state the first left
  task rd2(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk) begin i_addr <= a; i_rd <= 1'b1; end
    @(negedge i_mclk);
    @(negedge i_mclk) chk(o_rdata, e);
    @(posedge i_mclk) i_rd <= 1'b0;
    @(negedge i_mclk) chk(o_rdata, 32'h0);
  endtask
  task waitn(input int lim);
    n = 0;
    while (o_meas_start !== 1'b1 && n < lim) begin @(negedge i_mclk); n++; end
  endtask
  initial begin
    repeat (12) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rc(4'h1, 32'h1);
    rc(4'h3, 32'h00010001);
    rc(4'h8, 32'h00019910);
    rc(4'hA, 32'hC3500E10);
    rd2(4'h4, 32'h0);
    rc(4'hB, 32'h0);
    for (i = 0; i < 18; i++) begin
      wr(rows[i][71:68], rows[i][67:36]);
      rc(rows[i][35:32], rows[i][31:0]);
    end
    wr(4'h0, 32'h8);
    for (i = 0; i < 22; i++) wr(4'h9, {8'h00, 16'h0100 + i[15:0], i[7:0]});
    for (i = 0; i < 19; i++) rc(4'h4, {8'h00, 16'h0100 + i[15:0], i[7:0]});
    rc(4'h4, 32'h00FEA201);
    rd2(4'h4, 32'h0);
    wr(4'h9, 32'h00000105);
    wr(4'h0, 32'h8);
    rd2(4'h4, 32'h0);
    wr(4'h0, 32'h4);
    rc(4'h4, 32'h00FF2502);
    wr(4'h0, 32'h100);
    wr(4'h0, 32'h1);
    rc(4'h4, 32'h00FEAA03);
    wr(4'h1, 32'h11);
    wr(4'h0, 32'h1);
    rc(4'h4, 32'h00FEAA03);
    wr(4'h1, 32'h9);
    wr(4'h3, 32'h00020001);
    wr(4'h0, 32'h1);
    rc(4'h4, 32'h00FEAA03);
    wr(4'h6, 32'h8);
    @(posedge i_mclk) i_quest_set <= 16'h8;
    @(posedge i_mclk) i_quest_set <= 16'h0;
    repeat (3) @(negedge i_mclk);
    chk({31'h0, o_questionable_summary_bit}, 32'h1);
    rd2(4'h5, 32'h8);
    repeat (2) @(negedge i_mclk);
    chk({31'h0, o_questionable_summary_bit}, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(4'h3, cf[i]);
      wr(4'h1, 32'h2);
      s0 = starts;
      wr(4'h0, 32'h1);
      waitn(20000);
      chk({31'h0, n >= tk[i] && n <= tk[i] + 8}, 32'h1);
      // Remaining delays: one per later sample and per later trigger
      m = (2 * ns[i] - 1) * tk[i];
      n = 0;
      while (o_busy !== 1'b0 && n < 20000) begin @(negedge i_mclk); n++; end
      chk({31'h0, n >= m && n <= m + 16 * ns[i]}, 32'h1);
      chk({24'h0, starts - s0}, 2 * ns[i]);
    end
    wr(4'h2, 32'h0);
    wr(4'h3, 32'h00010004);
    wr(4'h1, 32'h1);
    s0 = starts;
    wr(4'h0, 32'h1);
    repeat (20) @(negedge i_mclk);
    chk({31'h0, o_waiting}, 32'h1);
    chk({24'h0, starts}, {24'h0, s0});
    @(posedge i_mclk) i_ext_trig_n <= 1'b0;
    waitn(10);
    chk({31'h0, n < 10}, 32'h1);
    @(posedge i_mclk) i_ext_trig_n <= 1'b1;
    repeat (10) @(negedge i_mclk);
    chk({31'h0, o_busy}, 32'h0);
    // Bus trigger while waiting starts a run and queues nothing
    wr(4'h3, 32'h00010002);
    wr(4'h0, 32'h1);
    wr(4'h0, 32'h4);
    waitn(10);
    chk({31'h0, n < 10}, 32'h1);
    repeat (10) @(negedge i_mclk);
    rc(4'h4, 32'h0);
    // Reset while idle, with state to lose
    wr(4'h9, 32'h00123456);
    wr(4'h1, 32'h5);
    @(posedge i_mclk) i_rstn <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rc(4'h1, 32'h1);
    rc(4'h3, 32'h00010001);
    rc(4'h4, 32'h0);
    stop_test;
  end
  // Whole test is near 30000 cycles; double it before giving up
  initial begin
    #(60000 * 50);
    fails++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
